// File: ral_relay_alarm.sv
// Contract
// - Five relays, each with own function code
// - Functions 3,4,6,7 accepted only when enabled
// - Diagnostic relay latched until program-to-run
// - Batch relays latched until batch reset
// - Rate high setpoint percent, default 100
// - Deviation limit percent of PID setpoint, default 10
// - Low setpoint default 20, rate only
// - Mode: 1 both, 2 high, 3 low
// - Dead band default 3.0 percent
// - No dead band for diagnostic, pre-warn, setpoint
// - Polarity 2 normal, 3 inverted
// - Override 0 normal, 1 on, 2 off
// - Damping 0 to 999 slows rate response
`timescale 1ns/1ns
`include "ral_consts.svh"
module ral_relay_alarm (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [9:0] rate_in,
    input wire logic [9:0] pid_setpoint_in,
    input wire logic diag_fault_in,
    input wire logic prewarn_in,
    input wire logic batch_setpoint_in,
    input wire logic online_cal_alarm_in,
    input wire logic batch_reset_in,
    input wire logic program_mode_in,
    output logic [4:0] relay_out,
    output logic [4:0] alarm_indication,
    output logic irq
);
    import ral_pkg::*;

    function automatic logic func_ok(input logic [2:0] code, input logic [2:0] en);
        logic ok;
        unique case (code)
            3'h3, 3'h4: ok = en[`RAL_EN_PID];
            3'h6: ok = en[`RAL_EN_BATCH];
            3'h7: ok = en[`RAL_EN_OCAL];
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction
    function automatic logic [9:0] sub_sat(input logic [9:0] a, input logic [9:0] b);
        return (a > b) ? a - b : 10'h000;
    endfunction
    function automatic logic [19:0] mul10(input logic [9:0] a, input logic [9:0] b);
        return 20'(a) * 20'(b);
    endfunction

    ral_func_type func_q [5], func_d [5];
    logic [9:0] hsp_q [5], hsp_d [5];
    logic [9:0] lsp_q [5], lsp_d [5];
    logic [1:0] mode_q [5], mode_d [5];
    logic [9:0] db_q [5], db_d [5];
    logic [1:0] pol_q [5], pol_d [5];
    logic [1:0] ovr_q [5], ovr_d [5];
    logic [9:0] damp_q, damp_d;
    logic [2:0] en_q, en_d;
    logic [4:0] imask_q, imask_d;

    always_comb begin
        for (int i = 0; i < `RAL_NUM_RELAYS; i++) begin
            func_d[i] = func_q[i];
            hsp_d[i] = hsp_q[i];
            lsp_d[i] = lsp_q[i];
            mode_d[i] = mode_q[i];
            db_d[i] = db_q[i];
            pol_d[i] = pol_q[i];
            ovr_d[i] = ovr_q[i];
            if (reg_wr && reg_addr[7:4] == 4'(i)) begin
                unique case (reg_addr[3:0])
                    `RAL_F_FUNC: begin
                        if (func_ok(reg_wdata[2:0], en_q)) begin
                            func_d[i] = ral_func_type'(reg_wdata[2:0]);
                            if (reg_wdata[2:0] == RAL_FN_DEV1 || reg_wdata[2:0] == RAL_FN_DEV2)
                                hsp_d[i] = `RAL_RST_DEV;
                            else if (reg_wdata[2:0] == RAL_FN_RATE)
                                hsp_d[i] = `RAL_RST_HSP;
                        end
                    end
                    `RAL_F_HSP: hsp_d[i] = reg_wdata[9:0];
                    `RAL_F_LSP: lsp_d[i] = reg_wdata[9:0];
                    `RAL_F_MODE: mode_d[i] = reg_wdata[1:0];
                    `RAL_F_DB: db_d[i] = reg_wdata[9:0];
                    `RAL_F_POL: pol_d[i] = reg_wdata[1:0];
                    `RAL_F_OVR: ovr_d[i] = reg_wdata[1:0];
                    default: ;
                endcase
            end
        end
        damp_d = damp_q;
        en_d = en_q;
        imask_d = imask_q;
        if (reg_wr && reg_addr[7:4] == `RAL_GLOBAL_SEL) begin
            if (reg_addr[3:0] == `RAL_G_DAMP && reg_wdata <= `RAL_DAMP_MAX)
                damp_d = reg_wdata[9:0];
            if (reg_addr[3:0] == `RAL_G_ENABLE)
                en_d = reg_wdata[2:0];
            if (reg_addr[3:0] == `RAL_G_IRQ_MASK)
                imask_d = reg_wdata[4:0];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            func_q <= '{default: RAL_FN_OFF};
            hsp_q <= '{default: `RAL_RST_HSP};
            lsp_q <= '{default: `RAL_RST_LSP};
            mode_q <= '{default: RAL_MD_BOTH};
            db_q <= '{default: `RAL_RST_DB};
            pol_q <= '{default: RAL_POL_NORMAL};
            ovr_q <= '{default: RAL_OV_NORMAL};
            damp_q <= 10'h000;
            en_q <= 3'h0;
            imask_q <= 5'h00;
        end else begin
            func_q <= func_d;
            hsp_q <= hsp_d;
            lsp_q <= lsp_d;
            mode_q <= mode_d;
            db_q <= db_d;
            pol_q <= pol_d;
            ovr_q <= ovr_d;
            damp_q <= damp_d;
            en_q <= en_d;
            imask_q <= imask_d;
        end
    end

    // Damped rate: steps toward the input once every damp+1 cycles
    logic [9:0] filt_q, filt_d;
    logic [9:0] dcnt_q, dcnt_d;
    logic [9:0] step;

    always_comb begin
        filt_d = filt_q;
        dcnt_d = dcnt_q + 10'h001;
        step = ((rate_in > filt_q) ? rate_in - filt_q : filt_q - rate_in) >> `RAL_STEP_SHIFT;
        if (step == 10'h000)
            step = 10'h001;
        if (damp_q == 10'h000) begin
            filt_d = rate_in;
            dcnt_d = 10'h000;
        end else if (dcnt_q >= damp_q) begin
            dcnt_d = 10'h000;
            if (rate_in > filt_q)
                filt_d = filt_q + step;
            else if (rate_in < filt_q)
                filt_d = filt_q - step;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            filt_q <= 10'h000;
            dcnt_q <= 10'h000;
        end else begin
            filt_q <= filt_d;
            dcnt_q <= dcnt_d;
        end
    end

    logic prog_q;
    logic run_entry;
    logic [19:0] dev_act;
    logic [4:0] hi_q, hi_d, lo_q, lo_d, alm_q, alm_d, eff;
    logic [4:0] out_q, out_d, ind_q, ind_d, ist_q, ist_d;
    logic irq_q;
    assign run_entry = prog_q & ~program_mode_in;
    assign dev_act = mul10((filt_q > pid_setpoint_in) ? filt_q - pid_setpoint_in
                           : pid_setpoint_in - filt_q, `RAL_DEV_SCALE);

    always_comb begin
        for (int i = 0; i < `RAL_NUM_RELAYS; i++) begin
            hi_d[i] = 1'b0;
            lo_d[i] = 1'b0;
            unique case (func_q[i])
                RAL_FN_OFF: alm_d[i] = 1'b0;
                RAL_FN_RATE: begin
                    hi_d[i] = hi_q[i];
                    if (filt_q > hsp_q[i])
                        hi_d[i] = 1'b1;
                    else if (filt_q < sub_sat(hsp_q[i], db_q[i]))
                        hi_d[i] = 1'b0;
                    lo_d[i] = lo_q[i];
                    if (filt_q < lsp_q[i])
                        lo_d[i] = 1'b1;
                    else if (11'(filt_q) > 11'(lsp_q[i]) + 11'(db_q[i]))
                        lo_d[i] = 1'b0;
                    if (mode_q[i] == RAL_MD_HIGH)
                        alm_d[i] = hi_d[i];
                    else if (mode_q[i] == RAL_MD_LOW)
                        alm_d[i] = lo_d[i];
                    else
                        alm_d[i] = hi_d[i] | lo_d[i];
                end
                RAL_FN_DEV1, RAL_FN_DEV2: begin
                    hi_d[i] = hi_q[i];
                    if (dev_act > mul10(hsp_q[i], pid_setpoint_in))
                        hi_d[i] = 1'b1;
                    else if (dev_act < mul10(sub_sat(hsp_q[i], db_q[i]), pid_setpoint_in))
                        hi_d[i] = 1'b0;
                    alm_d[i] = hi_d[i];
                end
                RAL_FN_DIAG: alm_d[i] = diag_fault_in | (alm_q[i] & ~run_entry);
                RAL_FN_PREWARN: alm_d[i] = prewarn_in | (alm_q[i] & ~batch_reset_in);
                RAL_FN_SETPT: alm_d[i] = batch_setpoint_in | (alm_q[i] & ~batch_reset_in);
                RAL_FN_OCAL: alm_d[i] = online_cal_alarm_in;
            endcase
            if (ovr_q[i] == RAL_OV_ON)
                eff[i] = 1'b1;
            else if (ovr_q[i] == RAL_OV_OFF)
                eff[i] = 1'b0;
            else
                eff[i] = alm_d[i];
            ind_d[i] = eff[i];
            if (func_q[i] == RAL_FN_OFF)
                out_d[i] = 1'b0;
            else
                out_d[i] = (pol_q[i] == RAL_POL_INVERT) ? ~eff[i] : eff[i];
        end
        ist_d = ist_q | (alm_d & ~alm_q);
        if (reg_wr && reg_addr == {`RAL_GLOBAL_SEL, `RAL_G_IRQ_STAT})
            ist_d = (ist_q & ~reg_wdata[4:0]) | (alm_d & ~alm_q);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prog_q <= 1'b0;
            hi_q <= 5'h00;
            lo_q <= 5'h00;
            alm_q <= 5'h00;
            out_q <= 5'h00;
            ind_q <= 5'h00;
            ist_q <= 5'h00;
            irq_q <= 1'b0;
        end else begin
            prog_q <= program_mode_in;
            hi_q <= hi_d;
            lo_q <= lo_d;
            alm_q <= alm_d;
            out_q <= out_d;
            ind_q <= ind_d;
            ist_q <= ist_d;
            irq_q <= |(ist_q & imask_q);
        end
    end

    logic [15:0] rdat_q, rdat_d;
    always_comb begin
        rdat_d = 16'h0000;
        if (reg_rd && reg_addr[7:4] < 4'h5) begin
            unique case (reg_addr[3:0])
                `RAL_F_FUNC: rdat_d = 16'(func_q[reg_addr[6:4]]);
                `RAL_F_HSP: rdat_d = 16'(hsp_q[reg_addr[6:4]]);
                `RAL_F_LSP: rdat_d = 16'(lsp_q[reg_addr[6:4]]);
                `RAL_F_MODE: rdat_d = 16'(mode_q[reg_addr[6:4]]);
                `RAL_F_DB: rdat_d = 16'(db_q[reg_addr[6:4]]);
                `RAL_F_POL: rdat_d = 16'(pol_q[reg_addr[6:4]]);
                `RAL_F_OVR: rdat_d = 16'(ovr_q[reg_addr[6:4]]);
                default: rdat_d = 16'h0000;
            endcase
        end else if (reg_rd && reg_addr[7:4] == `RAL_GLOBAL_SEL) begin
            unique case (reg_addr[3:0])
                `RAL_G_DAMP: rdat_d = 16'(damp_q);
                `RAL_G_ENABLE: rdat_d = 16'(en_q);
                `RAL_G_STATUS: rdat_d = {3'h0, ind_q, 3'h0, out_q};
                `RAL_G_IRQ_STAT: rdat_d = 16'(ist_q);
                `RAL_G_IRQ_MASK: rdat_d = 16'(imask_q);
                `RAL_G_RATE: rdat_d = 16'(filt_q);
                default: rdat_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            rdat_q <= 16'h0000;
        else
            rdat_q <= rdat_d;
    end

    assign reg_rdata = rdat_q;
    assign relay_out = out_q;
    assign alarm_indication = ind_q;
    assign irq = irq_q;

    AST_OFF_INACTIVE: assert property (
        @(posedge mclk) disable iff (sys_rst) func_q[0] == RAL_FN_OFF |=> !relay_out[0])
        else $error("relay 0 active while function off");
    AST_FUNC_GATED: assert property (
        @(posedge mclk) disable iff (sys_rst)
        reg_wr && reg_addr == 8'h10 && reg_wdata[2:0] == 3'h3 && !en_q[`RAL_EN_PID]
        |=> func_q[1] == $past(func_q[1]))
        else $error("deviation function taken while PID disabled");
    AST_DIAG_LATCH: assert property (
        @(posedge mclk) disable iff (sys_rst)
        func_q[2] == RAL_FN_DIAG && alm_q[2] && !run_entry |=> alm_q[2])
        else $error("diagnostic alarm dropped without run entry");
    AST_BATCH_LATCH: assert property (
        @(posedge mclk) disable iff (sys_rst)
        func_q[3] == RAL_FN_SETPT && alm_q[3] && !batch_reset_in |=> alm_q[3])
        else $error("batch alarm dropped without batch reset");
    AST_HIGH_TRIP: assert property (
        @(posedge mclk) disable iff (sys_rst)
        func_q[0] == RAL_FN_RATE && mode_q[0] == RAL_MD_HIGH && filt_q > hsp_q[0] |=> alm_q[0])
        else $error("high alarm missed");
    AST_LOW_ONLY_CLEAR: assert property (
        @(posedge mclk) disable iff (sys_rst)
        func_q[0] == RAL_FN_RATE && mode_q[0] == RAL_MD_LOW
        && 11'(filt_q) > 11'(lsp_q[0]) + 11'(db_q[0]) |=> !alm_q[0])
        else $error("low-only alarm set above low band");
    AST_HYST_HOLD: assert property (
        @(posedge mclk) disable iff (sys_rst)
        func_q[0] == RAL_FN_RATE && hi_q[0] && filt_q >= sub_sat(hsp_q[0], db_q[0])
        |=> hi_q[0])
        else $error("high alarm cleared inside dead band");
    AST_INVERT_FORCE: assert property (
        @(posedge mclk) disable iff (sys_rst)
        func_q[0] != RAL_FN_OFF && ovr_q[0] == RAL_OV_ON && pol_q[0] == RAL_POL_INVERT
        |=> !relay_out[0] && alarm_indication[0])
        else $error("inverted forced relay not open");
    AST_FORCE_OFF: assert property (
        @(posedge mclk) disable iff (sys_rst)
        ovr_q[0] == RAL_OV_OFF && pol_q[0] == RAL_POL_NORMAL |=> !relay_out[0] ##0 !alarm_indication[0])
        else $error("forced-off relay active");
    AST_NO_DAMP: assert property (
        @(posedge mclk) disable iff (sys_rst) damp_q == 10'h000 |=> filt_q == $past(rate_in))
        else $error("undamped rate not tracking input");
endmodule

// File: ral_consts.svh
`ifndef RAL_CONSTS_SVH
`define RAL_CONSTS_SVH
`define RAL_NUM_RELAYS 5
`define RAL_GLOBAL_SEL 4'h8
`define RAL_F_FUNC 4'h0
`define RAL_F_HSP 4'h1
`define RAL_F_LSP 4'h2
`define RAL_F_MODE 4'h3
`define RAL_F_DB 4'h4
`define RAL_F_POL 4'h5
`define RAL_F_OVR 4'h6
`define RAL_G_DAMP 4'h0
`define RAL_G_ENABLE 4'h1
`define RAL_G_STATUS 4'h2
`define RAL_G_IRQ_STAT 4'h3
`define RAL_G_IRQ_MASK 4'h4
`define RAL_G_RATE 4'h5
`define RAL_EN_PID 0
`define RAL_EN_BATCH 1
`define RAL_EN_OCAL 2
`define RAL_RST_HSP 10'h3e8
`define RAL_RST_DEV 10'h064
`define RAL_RST_LSP 10'h0c8
`define RAL_RST_DB 10'h01e
`define RAL_DEV_SCALE 10'h3e8
`define RAL_STEP_SHIFT 3
`define RAL_DAMP_MAX 16'h03e7
`endif

// File: ral_pkg.sv
package ral_pkg;
    typedef enum logic [2:0] {
        RAL_FN_OFF = 3'h0,
        RAL_FN_RATE = 3'h1,
        RAL_FN_DIAG = 3'h2,
        RAL_FN_DEV1 = 3'h3,
        RAL_FN_DEV2 = 3'h4,
        RAL_FN_PREWARN = 3'h5,
        RAL_FN_SETPT = 3'h6,
        RAL_FN_OCAL = 3'h7
    } ral_func_type;
    typedef enum logic [1:0] {
        RAL_MD_BOTH = 2'h1,
        RAL_MD_HIGH = 2'h2,
        RAL_MD_LOW = 2'h3
    } ral_mode_type;
    typedef enum logic [1:0] {
        RAL_OV_NORMAL = 2'h0,
        RAL_OV_ON = 2'h1,
        RAL_OV_OFF = 2'h2
    } ral_ovr_type;
    localparam logic [1:0] RAL_POL_NORMAL = 2'h2;
    localparam logic [1:0] RAL_POL_INVERT = 2'h3;
endpackage

// File: ral_contact_load.sv
`timescale 1ns/1ns
module ral_contact_load (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [4:0] relay_out,
    output logic [7:0] close_count
);
    logic [4:0] contact_q;
    logic [7:0] close_q;
    // Counts every contact that pulls in, so chatter shows up as extra closures
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            contact_q <= 5'h00;
            close_q <= 8'h00;
        end else begin
            contact_q <= relay_out;
            close_q <= close_q + 8'($countones(relay_out & ~contact_q));
        end
    end
    assign close_count = close_q;
endmodule

// File: relay_alarm_logic_test.sv
`timescale 1ns/1ns
`include "ral_consts.svh"
module relay_alarm_logic_test;
    import ral_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [9:0] rate_in = 10'h000;
    logic [9:0] pid_setpoint_in = 10'h000;
    logic diag_fault_in = 1'b0, prewarn_in = 1'b0, batch_setpoint_in = 1'b0;
    logic online_cal_alarm_in = 1'b0, batch_reset_in = 1'b0, program_mode_in = 1'b0;
    logic [4:0] relay_out;
    logic [4:0] alarm_indication;
    logic irq;
    logic [7:0] close_count;
    int fails = 0;
    int comparisons = 0;

    ral_relay_alarm dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rate_in(rate_in), .pid_setpoint_in(pid_setpoint_in), .diag_fault_in(diag_fault_in),
        .prewarn_in(prewarn_in), .batch_setpoint_in(batch_setpoint_in),
        .online_cal_alarm_in(online_cal_alarm_in), .batch_reset_in(batch_reset_in),
        .program_mode_in(program_mode_in), .relay_out(relay_out),
        .alarm_indication(alarm_indication), .irq(irq));
    ral_contact_load load (.mclk(mclk), .sys_rst(sys_rst), .relay_out(relay_out),
        .close_count(close_count));

    always #10 mclk = ~mclk;

    task automatic final_report();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] ra(input int r, input logic [3:0] f);
        return {4'(r), f};
    endfunction

    function automatic logic [7:0] ga(input logic [3:0] f);
        return {`RAL_GLOBAL_SEL, f};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic rate(input logic [9:0] r);
        @(posedge mclk);
        rate_in <= r;
    endtask

    // Bounded wait for a relay to reach a level; running out ends the run
    task automatic wait_relay(input int i, input logic v);
        #1;
        repeat (30) begin
            if (relay_out[i] === v) break;
            @(posedge mclk);
            #1;
        end
        chk(16'(relay_out[i]), 16'(v));
        if (relay_out[i] !== v) final_report();
    endtask

    task automatic hold_relay(input int i, input logic v);
        repeat (6) @(posedge mclk);
        #1;
        chk(16'(relay_out[i]), 16'(v));
    endtask

    task automatic t_reset();
        logic [15:0] exp [7];
        exp = '{16'h0000, 16'(`RAL_RST_HSP), 16'(`RAL_RST_LSP), 16'h0001, 16'(`RAL_RST_DB),
            16'(RAL_POL_NORMAL), 16'h0000};
        #1;
        chk({11'h000, relay_out}, 16'h0000);
        for (int r = 0; r < 5; r++) begin
            for (int f = 0; f < 7; f++) begin
                rd_chk(ra(r, 4'(f)), exp[f]);
            end
        end
        rd_chk(ga(`RAL_G_DAMP), 16'h0000);
        rd_chk(8'h57, 16'h0000);
        rd_chk(8'h8f, 16'h0000);
    endtask

    task automatic t_func_gate();
        int codes [4] = '{3, 4, 6, 7};
        int bits [4] = '{1, 1, 2, 4};
        foreach (codes[k]) begin
            wr(ga(`RAL_G_ENABLE), 16'(bits[k]) ^ 16'h0007);
            wr(ra(1, `RAL_F_FUNC), 16'(codes[k]));
            rd_chk(ra(1, `RAL_F_FUNC), 16'h0000);
            wr(ga(`RAL_G_ENABLE), 16'(bits[k]));
            wr(ra(1, `RAL_F_FUNC), 16'(codes[k]));
            rd_chk(ra(1, `RAL_F_FUNC), 16'(codes[k]));
            wr(ra(1, `RAL_F_FUNC), 16'h0000);
        end
        wr(ga(`RAL_G_ENABLE), 16'h0007);
        for (int c = 7; c >= 0; c--) begin
            wr(ra(1, `RAL_F_FUNC), 16'(c));
            rd_chk(ra(1, `RAL_F_FUNC), 16'(c));
        end
        wr(ra(1, `RAL_F_FUNC), 16'h0003);
        rd_chk(ra(1, `RAL_F_HSP), 16'(`RAL_RST_DEV));
        wr(ra(1, `RAL_F_FUNC), 16'h0001);
        rd_chk(ra(1, `RAL_F_HSP), 16'(`RAL_RST_HSP));
        wr(ra(1, `RAL_F_FUNC), 16'h0000);
    endtask

    task automatic t_high();
        logic [7:0] c0;
        logic [15:0] d;
        wr(ra(0, `RAL_F_FUNC), 16'h0001);
        wr(ra(0, `RAL_F_MODE), 16'(RAL_MD_HIGH));
        wr(ra(0, `RAL_F_HSP), 16'd500);
        wr(ga(`RAL_G_IRQ_STAT), 16'h001f);
        rate(10'd500);
        hold_relay(0, 1'b0);
        c0 = close_count;
        rate(10'd501);
        wait_relay(0, 1'b1);
        rd(ga(`RAL_G_IRQ_STAT), d);
        chk(d & 16'h0001, 16'h0001);
        chk(16'(irq), 16'h0000);
        wr(ga(`RAL_G_IRQ_MASK), 16'h0001);
        repeat (3) @(posedge mclk);
        #1;
        chk(16'(irq), 16'h0001);
        wr(ga(`RAL_G_IRQ_STAT), 16'h0001);
        repeat (3) @(posedge mclk);
        #1;
        chk(16'(irq), 16'h0000);
        rate(10'd471);
        hold_relay(0, 1'b1);
        rate(10'd469);
        wait_relay(0, 1'b0);
        chk(16'(close_count - c0), 16'h0001);
        rate(10'd100);
        hold_relay(0, 1'b0);
        rate(10'd300);
    endtask

    task automatic t_low();
        wr(ra(0, `RAL_F_MODE), 16'(RAL_MD_LOW));
        rate(10'd900);
        hold_relay(0, 1'b0);
        rate(10'd199);
        wait_relay(0, 1'b1);
        rate(10'd229);
        hold_relay(0, 1'b1);
        rate(10'd231);
        wait_relay(0, 1'b0);
        wr(ra(0, `RAL_F_MODE), 16'(RAL_MD_BOTH));
        rate(10'd600);
        wait_relay(0, 1'b1);
        rate(10'd300);
        wait_relay(0, 1'b0);
    endtask

    task automatic t_pol_ovr();
        wr(ra(0, `RAL_F_POL), 16'(RAL_POL_INVERT));
        hold_relay(0, 1'b1);
        wr(ra(0, `RAL_F_POL), 16'(RAL_POL_NORMAL));
        hold_relay(0, 1'b0);
        wr(ra(0, `RAL_F_OVR), 16'(RAL_OV_ON));
        hold_relay(0, 1'b1);
        rd_chk(ga(`RAL_G_STATUS), 16'h0101);
        wr(ra(0, `RAL_F_POL), 16'(RAL_POL_INVERT));
        hold_relay(0, 1'b0);
        chk(16'(alarm_indication[0]), 16'h0001);
        wr(ra(0, `RAL_F_POL), 16'(RAL_POL_NORMAL));
        rate(10'd600);
        wr(ra(0, `RAL_F_OVR), 16'(RAL_OV_OFF));
        hold_relay(0, 1'b0);
        chk(16'(alarm_indication[0]), 16'h0000);
        wr(ra(0, `RAL_F_OVR), 16'(RAL_OV_NORMAL));
        wait_relay(0, 1'b1);
        wr(ra(0, `RAL_F_POL), 16'(RAL_POL_INVERT));
        wait_relay(0, 1'b0);
        wr(ra(1, `RAL_F_OVR), 16'(RAL_OV_ON));
        hold_relay(1, 1'b0);
        chk(16'(alarm_indication[1]), 16'h0001);
        wr(ra(1, `RAL_F_OVR), 16'(RAL_OV_NORMAL));
        wr(ra(0, `RAL_F_POL), 16'(RAL_POL_NORMAL));
        rate(10'd500);
    endtask

    task automatic t_dev();
        @(posedge mclk);
        pid_setpoint_in <= 10'd500;
        wr(ra(1, `RAL_F_FUNC), 16'h0003);
        hold_relay(1, 1'b0);
        rate(10'd600);
        wait_relay(1, 1'b1);
        rate(10'd500);
        wait_relay(1, 1'b0);
        wr(ra(1, `RAL_F_FUNC), 16'h0000);
    endtask

    task automatic t_latch();
        wr(ra(2, `RAL_F_FUNC), 16'h0002);
        wr(ra(3, `RAL_F_FUNC), 16'h0006);
        wr(ra(4, `RAL_F_FUNC), 16'h0005);
        wr(ra(4, `RAL_F_DB), 16'h03e7);
        @(posedge mclk);
        diag_fault_in <= 1'b1;
        batch_setpoint_in <= 1'b1;
        prewarn_in <= 1'b1;
        @(posedge mclk);
        diag_fault_in <= 1'b0;
        batch_setpoint_in <= 1'b0;
        prewarn_in <= 1'b0;
        wait_relay(2, 1'b1);
        hold_relay(3, 1'b1);
        hold_relay(4, 1'b1);
        @(posedge mclk);
        batch_reset_in <= 1'b1;
        program_mode_in <= 1'b1;
        @(posedge mclk);
        batch_reset_in <= 1'b0;
        wait_relay(3, 1'b0);
        wait_relay(4, 1'b0);
        hold_relay(2, 1'b1);
        @(posedge mclk);
        program_mode_in <= 1'b0;
        wait_relay(2, 1'b0);
        wr(ra(4, `RAL_F_FUNC), 16'h0007);
        @(posedge mclk);
        online_cal_alarm_in <= 1'b1;
        wait_relay(4, 1'b1);
        @(posedge mclk);
        online_cal_alarm_in <= 1'b0;
        wait_relay(4, 1'b0);
    endtask

    task automatic t_damp();
        logic [15:0] d;
        wr(ga(`RAL_G_DAMP), 16'd3);
        rate(10'd800);
        rd(ga(`RAL_G_RATE), d);
        chk(16'(d !== 16'd800), 16'h0001);
        wr(ga(`RAL_G_DAMP), 16'd1000);
        rd_chk(ga(`RAL_G_DAMP), 16'd3);
        wr(ga(`RAL_G_DAMP), 16'd999);
        rd_chk(ga(`RAL_G_DAMP), 16'd999);
        wr(ga(`RAL_G_DAMP), 16'd0);
        rate(10'd123);
        repeat (3) @(posedge mclk);
        rd_chk(ga(`RAL_G_RATE), 16'd123);
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_func_gate();
        t_high();
        t_low();
        t_pol_ovr();
        t_dev();
        t_latch();
        t_damp();
        final_report();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        fails++;
        final_report();
    end
endmodule
